//--- hdl/pfd_params.svh
// Reset values for the registers of the phase and frequency detector
`ifndef PFD_PARAMS_SVH
`define PFD_PARAMS_SVH
`define PFD_DIV_RST   1'b0
`define PFD_FLAG_RST  1'b1
`define PFD_OUT_RST   1'b0
`define PFD_SYNC_RST  2'b00
`endif

//--- hdl/pfd_pkg.sv
// Types shared by the phase and frequency detector
package pfd_pkg;
  // One sample of both edge inputs
  typedef struct packed {
    logic reference;
    logic oscillator;
  } edge_pair_t;

  // Operating mode, one-hot
  typedef enum logic [2:0] {
    MODE_PHASE = 3'b001,
    MODE_SLOW  = 3'b010,
    MODE_FAST  = 3'b100
  } mode_t;
endpackage

//--- hdl/phase_freq_detector.sv
// Sampled phase and frequency detector with complementary output pair
`timescale 1ns/100ps
`include "pfd_params.svh"

// Overview of operation
// - Reference and oscillator inputs go through identical logic so their roles can be swapped.
// - The outputs are a true result and its exact complement.
// - The core is two divider flops, two order-tracking flops, two discriminator flops, one XOR and output logic.
// - The block is either in linear phase detection or in frequency discrimination.
// - With inputs close in frequency only the XOR path sets the output.
// - With inputs far apart a discriminator flag overrides the XOR toward the reference.
// - In phase mode the output duty cycle follows the phase difference.
// - Each input first toggles a divide-by-two flop to give square waves.
// - Inputs 180 degrees apart, 90 degrees once halved, give a 50 percent duty cycle, the lock point.
// - Two edges of one input before one of the other drop the matching flag low.
// - Near lock both flags stay high and the XOR passes straight through.
module phase_freq_detector
  import pfd_pkg::*;
(
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst,
  // Edge inputs from pins
  input  wire logic reference_in,
  input  wire logic oscillator_feedback_in,
  // Detector outputs
  output logic      detector_out,
  output logic      detector_out_n,
  output mode_t     mode
);

  // Synchronisers and edge history
  logic [1:0] sync_ref;
  logic [1:0] sync_osc;
  edge_pair_t last_level;
  edge_pair_t edge_seen;

  // Core detector state
  edge_pair_t div;
  edge_pair_t pending;
  logic       freq_low_n;
  logic       freq_high_n;
  edge_pair_t next_div;
  edge_pair_t next_pending;
  logic       next_freq_low_n;
  logic       next_freq_high_n;
  logic       next_out;
  mode_t      next_mode;

  // Two-flop synchronisers; pins are asynchronous to clk_sys
  // Costs three cycles per edge, so each input level must last two cycles
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sync_ref   <= `PFD_SYNC_RST;
      sync_osc   <= `PFD_SYNC_RST;
      last_level <= '0;
    end else begin
      sync_ref   <= {sync_ref[0], reference_in};
      sync_osc   <= {sync_osc[0], oscillator_feedback_in};
      last_level <= '{reference: sync_ref[1], oscillator: sync_osc[1]};
    end
  end

  // Rising edges, seen only on the settled stage
  // identical paths
  always_comb begin
    edge_seen.reference  = sync_ref[1] & ~last_level.reference;
    edge_seen.oscillator = sync_osc[1] & ~last_level.oscillator;
  end

  // Next state of dividers, order tracking and discriminator flags
  always_comb begin
    next_div.reference  = div.reference ^ edge_seen.reference;
    next_div.oscillator = div.oscillator ^ edge_seen.oscillator;
    // Remember which input edged last; coincident edges cancel
    next_pending.reference  = edge_seen.reference ? ~edge_seen.oscillator
                            : (edge_seen.oscillator ? 1'b0 : pending.reference);
    next_pending.oscillator = edge_seen.oscillator ? ~edge_seen.reference
                            : (edge_seen.reference ? 1'b0 : pending.oscillator);
    next_freq_low_n  = freq_low_n;
    next_freq_high_n = freq_high_n;
    if (edge_seen.oscillator) begin
      next_freq_low_n = 1'b1;
    end
    if (edge_seen.reference) begin
      next_freq_high_n = 1'b1;
    end
    if (edge_seen.reference && pending.reference && !edge_seen.oscillator) begin
      next_freq_low_n = 1'b0;
    end
    if (edge_seen.oscillator && pending.oscillator && !edge_seen.reference) begin
      next_freq_high_n = 1'b0;
    end
  end

  // Output selection from the present core state
  always_comb begin
    if (!freq_low_n) begin
      next_out  = 1'b1;  // Slow oscillator: push tuning up
      next_mode = MODE_SLOW;
    end else if (!freq_high_n) begin
      next_out  = 1'b0;  // Fast oscillator: push tuning down
      next_mode = MODE_FAST;
    end else begin
      next_out  = div.reference ^ div.oscillator;
      next_mode = MODE_PHASE;
    end
  end

  // Register core state and outputs
  // six core flops
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      div            <= '{reference: `PFD_DIV_RST, oscillator: `PFD_DIV_RST};
      pending        <= '0;
      freq_low_n     <= `PFD_FLAG_RST;
      freq_high_n    <= `PFD_FLAG_RST;
      detector_out   <= `PFD_OUT_RST;
      detector_out_n <= ~`PFD_OUT_RST;
      mode           <= MODE_PHASE;
    end else begin
      div            <= next_div;
      pending        <= next_pending;
      freq_low_n     <= next_freq_low_n;
      freq_high_n    <= next_freq_high_n;
      detector_out   <= next_out;
      detector_out_n <= ~next_out;
      mode           <= next_mode;
    end
  end

  // Checks on the detector's own behaviour
  sequence s_ref_twice;
    edge_seen.reference && pending.reference && !edge_seen.oscillator;
  endsequence

  sequence s_osc_twice;
    edge_seen.oscillator && pending.oscillator && !edge_seen.reference;
  endsequence

  property p_complement;
    @(posedge clk_sys) disable iff (rst) detector_out_n == !detector_out;
  endproperty
  a_complement: assert property (p_complement)
    else $error("output pair not complementary");

  property p_ref_slow;
    @(posedge clk_sys) disable iff (rst) s_ref_twice |=> !freq_low_n ##1 detector_out;
  endproperty
  a_ref_slow: assert property (p_ref_slow)
    else $error("double reference edge did not force output high");

  property p_osc_fast;
    @(posedge clk_sys) disable iff (rst) s_osc_twice |=> !freq_high_n ##1 !detector_out;
  endproperty
  a_osc_fast: assert property (p_osc_fast)
    else $error("double oscillator edge did not force output low");

  property p_release;
    @(posedge clk_sys) disable iff (rst)
      (!freq_low_n && edge_seen.oscillator) |=> freq_low_n;
  endproperty
  a_release: assert property (p_release)
    else $error("slow flag not released by oscillator edge");

  property p_divide;
    @(posedge clk_sys) disable iff (rst)
      edge_seen.reference |=> div.reference != $past(div.reference);
  endproperty
  a_divide: assert property (p_divide)
    else $error("reference divider did not toggle");

  property p_pass;
    @(posedge clk_sys) disable iff (rst)
      (freq_low_n && freq_high_n) |=> detector_out == $past(div.reference ^ div.oscillator);
  endproperty
  a_pass: assert property (p_pass)
    else $error("xor result not passed through near lock");

  property p_override;
    @(posedge clk_sys) disable iff (rst)
      (!freq_high_n && freq_low_n) |=> !detector_out && mode == MODE_FAST;
  endproperty
  a_override: assert property (p_override)
    else $error("fast flag did not override output");

  property p_mode;
    @(posedge clk_sys) disable iff (rst)
      $onehot(mode) && ((mode == MODE_PHASE) == $past(freq_low_n && freq_high_n));
  endproperty
  a_mode: assert property (p_mode)
    else $error("mode does not match discriminator flags");

  property p_override_slow;
    @(posedge clk_sys) disable iff (rst)
      !freq_low_n |=> detector_out && mode == MODE_SLOW;
  endproperty
  a_override_slow: assert property (p_override_slow)
    else $error("slow flag did not override output");

  property p_release_fast;
    @(posedge clk_sys) disable iff (rst)
      (!freq_high_n && edge_seen.reference) |=> freq_high_n;
  endproperty
  a_release_fast: assert property (p_release_fast)
    else $error("fast flag not released by reference edge");

  property p_divide_osc;
    @(posedge clk_sys) disable iff (rst)
      edge_seen.oscillator |=> div.oscillator != $past(div.oscillator);
  endproperty
  a_divide_osc: assert property (p_divide_osc)
    else $error("oscillator divider did not toggle");

  property p_phase_mode;
    @(posedge clk_sys) disable iff (rst)
      (freq_low_n && freq_high_n) |=> mode == MODE_PHASE;
  endproperty
  a_phase_mode: assert property (p_phase_mode)
    else $error("phase mode not selected with both flags high");

endmodule

//--- sim/sq_source.sv
// Square wave source used for the reference and the oscillator
`timescale 1ns/100ps
module sq_source (
  // Clock
  input  wire logic       clk_sys,
  // Control
  input  wire logic       run,
  input  wire logic [7:0] half,
  // Wave out
  output logic            wave = 1'b0
);
  logic [7:0] cnt = 8'h00;
  // Parks low while stopped, as an idle oscillator would
  always @(posedge clk_sys) begin
    if (!run) begin
      cnt <= 8'h00;
      wave <= 1'b0;
    end else if (cnt == half - 8'h01) begin
      cnt <= 8'h00;
      wave <= ~wave;
    end else begin
      cnt <= cnt + 8'h01;
    end
  end
endmodule

//--- sim/digital_phase_freq_detector_bench.sv
// Self-checking bench for the phase and frequency detector
`timescale 1ns/100ps
module digital_phase_freq_detector_bench;
  import pfd_pkg::*;
  logic  clk_sys = 1'b0;
  logic  rst = 1'b1;
  logic  run_r = 1'b0;
  logic  run_o = 1'b0;
  logic  ref_w;
  logic  osc_w;
  logic  dout;
  logic  dout_n;
  mode_t mode;
  int    n_fail = 0;
  int    comparisons = 0;
  int    cycles = 0;
  int    hi;
  int    k;

  always #5 clk_sys = ~clk_sys;

  // Both inputs come from identical sources
  sq_source ref_src (.clk_sys(clk_sys), .run(run_r), .half(8'h08), .wave(ref_w));
  sq_source vco (.clk_sys(clk_sys), .run(run_o), .half(8'h08), .wave(osc_w));
  phase_freq_detector dut (.clk_sys(clk_sys), .rst(rst), .reference_in(ref_w),
    .oscillator_feedback_in(osc_w), .detector_out(dout), .detector_out_n(dout_n),
    .mode(mode));

  task automatic finish_test();
    if (n_fail == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input logic c, input string msg);
    comparisons++;
    if (c !== 1'b1) begin
      n_fail++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask

  // High cycles in a 128-cycle window: four 32-cycle periods, 2*offset high each
  function automatic int expected_high(input int offset);
    return 8 * offset;
  endfunction

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // Stop both sources and flush the synchronisers
  task automatic restart();
    run_r <= 1'b0;
    run_o <= 1'b0;
    rst <= 1'b1;
    tick(3);
    rst <= 1'b0;
    tick(1);
  endtask

  // Watchdog plus checks that hold on every cycle
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles > 5000) begin
      n_fail++;
      finish_test();
    end
    if (!rst) begin
      check((dout ^ dout_n) === 1'b1, "outputs not complementary");
      check(mode inside {MODE_PHASE, MODE_SLOW, MODE_FAST}, "bad mode");
    end
  end

  initial begin
    void'($urandom(32'ha8a7_8d6a));
    tick(6);
    rst <= 1'b0;
    tick(1);
    check(dout === 1'b0 && dout_n === 1'b1 && mode === MODE_PHASE, "reset state");
    // One input alone forces the override, the other releases it
    for (int s = 0; s < 2; s++) begin
      restart();
      if (s == 0) run_r <= 1'b1;
      else run_o <= 1'b1;
      tick(40);
      check(dout === (s == 0) && mode === (s == 0 ? MODE_SLOW : MODE_FAST), "override");
      if (s == 0) run_o <= 1'b1;
      else run_r <= 1'b1;
      tick(20);
      check(mode === MODE_PHASE, "override kept");
    end
    // Lock point, coincident edges, then random offsets
    for (int t = 0; t < 5; t++) begin
      k = (t == 0) ? 8 : (t == 1) ? 0 : $urandom_range(15, 1);
      restart();
      run_r <= 1'b1;
      tick(k);
      run_o <= 1'b1;
      tick(64);
      hi = 0;
      repeat (128) begin
        @(posedge clk_sys);
        hi += dout;
      end
      check(hi == expected_high(k) && mode === MODE_PHASE, "duty");
    end
    finish_test();
  end
endmodule
